// *** cbd_bus_cycle_decoder.sv ***
// Operation
// (RULE1) a cycle without bus need is one clock long and shown as a read
// (RULE2) vectors come from the top page, high byte read before low byte
// (RULE3) each push writes one byte at the stack pointer address
// (RULE4) each pop reads one byte from the stack
// (RULE5) operand reads and writes move one byte in one bus cycle
// (RULE6) operands after the opcode are one or two bytes, set by mode
// (RULE7) post-increment mode addresses with index, then increments it
// (RULE8) offset post-increment adds 8-bit offset, then increments index
// (RULE9) indexed modes with unsigned 8-bit and 16-bit offsets
// (RULE10) stack-relative mode with an 8-bit offset
// (RULE11) stack-relative mode with a 16-bit offset
// (RULE12) relative branches carry one displacement byte added to pc
// (RULE13) displacement is signed, reaching -128 to +127
// (RULE14) second opcode page only after the prebyte
// (RULE15) program fetch reads the next address and advances pc by one
`timescale 1ns/10ps
`default_nettype none
module cbd_bus_cycle_decoder import cbd_pkg::*; (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // memory bus
  output logic [15:0]      addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic [7:0]       wdata_o,
  input  wire logic [7:0]  rdata_i,
  // execution side
  input  wire logic        taken_i,
  input  wire logic        vec_req_i,
  input  wire logic [7:0]  vec_sel_i,
  output logic [7:0]       opcode_o,
  output logic             page2_o,
  output logic [7:0]       operand_o,
  output logic             operand_vld_o,
  output logic [15:0]      pc_o,
  output logic [15:0]      sp_o,
  output logic [15:0]      hx_o,
  output logic [7:0]       acc_o
);
`include "cbd_regs.svh"

  cbd_seq_t    q_r;
  cbd_seq_t    q_nxt;
  cbd_mode_t   mode;
  cbd_cls_t    cls;
  logic [1:0]  nbytes;
  cbd_reg_t    rsel;
  logic [7:0]  dec_opc;
  logic [15:0] opr_in;
  logic [15:0] ea;
  logic [15:0] target;
  logic        pinc;

  // decode the byte being fetched, or the held opcode later on
  assign dec_opc = (q_r.st == CBD_S_FETCH) ? rdata_i : q_r.opc;
  assign opr_in  = (q_r.st == CBD_S_FETCH) ? 16'h0000
                                           : {q_r.opr[7:0], rdata_i};
  assign pinc    = (mode == CBD_M_IXP) || (mode == CBD_M_IX1P);

  cbd_mode_decode u_dec (
    .opc_i    (dec_opc),
    .page2_i  (q_r.page2),
    .mode_o   (mode),
    .cls_o    (cls),
    .nbytes_o (nbytes),
    .rsel_o   (rsel)
  );

  cbd_addr_gen u_agen (
    .mode_i   (mode),
    .hx_i     (q_r.hx),
    .sp_i     (q_r.sp),
    .pc_i     (q_r.pc),
    .opr_i    (opr_in),
    .ea_o     (ea),
    .target_o (target)
  );

  // next bus cycle and register updates
  always_comb begin
    logic        exec;
    logic        fetch_req;
    logic [15:0] fetch_pc;
    logic        ld_en;
    logic [7:0]  ld_val;
    logic [7:0]  src;
    exec      = 1'b0;
    fetch_req = 1'b0;
    fetch_pc  = q_r.pc;
    ld_en     = 1'b0;
    ld_val    = rdata_i;
    src       = q_r.acc;
    case (rsel)
      CBD_R_X: src = q_r.hx[7:0];
      CBD_R_H: src = q_r.hx[15:8];
      default: src = q_r.acc;
    endcase
    q_nxt      = q_r;
    q_nxt.rd   = 1'b1;
    q_nxt.wr   = 1'b0;
    q_nxt.dvld = 1'b0;
    case (q_r.st)
      CBD_S_VEC_HI: begin
        q_nxt.pc[15:8] = rdata_i;                    // RULE2
        q_nxt.st       = CBD_S_VEC_LO;
        q_nxt.addr     = q_r.addr | 16'h0001;        // RULE2
      end
      CBD_S_VEC_LO: begin
        fetch_req = 1'b1;
        fetch_pc  = {q_r.pc[15:8], rdata_i};
      end
      CBD_S_FETCH: begin
        q_nxt.opc = rdata_i;
        q_nxt.opr = 16'h0000;
        if (rdata_i == `CBD_PREBYTE && !q_r.page2) begin
          q_nxt.page2 = 1'b1;                        // RULE14
          fetch_req   = 1'b1;
        end else if (nbytes == 2'h0) begin
          exec = 1'b1;
        end else begin
          q_nxt.st    = CBD_S_OPR1;                  // RULE6
          q_nxt.addr  = q_r.pc;
          q_nxt.pc    = q_r.pc + 16'h0001;           // RULE15
          q_nxt.nleft = nbytes;
        end
      end
      CBD_S_OPR1, CBD_S_OPR2: begin
        q_nxt.opr = opr_in;
        if (q_r.nleft == 2'h2) begin
          q_nxt.nleft = 2'h1;
          q_nxt.st    = CBD_S_OPR2;                  // RULE6
          q_nxt.addr  = q_r.pc;
          q_nxt.pc    = q_r.pc + 16'h0001;           // RULE15
        end else begin
          exec = 1'b1;
        end
      end
      CBD_S_FREE: begin
        fetch_req = 1'b1;
      end
      CBD_S_READ: begin
        q_nxt.data = rdata_i;                        // RULE5
        q_nxt.dvld = 1'b1;
        ld_en      = 1'b1;
        fetch_req  = 1'b1;
        if (pinc) begin
          q_nxt.hx = q_r.hx + 16'h0001;              // RULE7 RULE8
        end
      end
      CBD_S_WRITE: begin
        fetch_req = 1'b1;
        if (pinc) begin
          q_nxt.hx = q_r.hx + 16'h0001;              // RULE7 RULE8
        end
      end
      CBD_S_PUSH: begin
        q_nxt.sp  = q_r.sp - 16'h0001;               // RULE3
        fetch_req = 1'b1;
      end
      CBD_S_POP: begin
        ld_en     = 1'b1;                            // RULE4
        fetch_req = 1'b1;
      end
      default: begin
        q_nxt.st   = CBD_S_VEC_HI;
        q_nxt.addr = {`CBD_VEC_PAGE, `CBD_RST_VEC_LO};
      end
    endcase
    // start the bus cycles of a fully decoded instruction
    if (exec) begin
      q_nxt.page2 = 1'b0;
      case (cls)
        CBD_C_READ: begin
          if (mode == CBD_M_IMM) begin
            q_nxt.data = opr_in[7:0];
            q_nxt.dvld = 1'b1;
            ld_val     = opr_in[7:0];
            ld_en      = 1'b1;
            fetch_req  = 1'b1;
          end else begin
            q_nxt.st   = CBD_S_READ;                 // RULE5
            q_nxt.addr = ea;
          end
        end
        CBD_C_WRITE: begin
          q_nxt.st    = CBD_S_WRITE;                 // RULE5
          q_nxt.addr  = ea;
          q_nxt.rd    = 1'b0;
          q_nxt.wr    = 1'b1;
          q_nxt.wdata = src;
        end
        CBD_C_PUSH: begin
          q_nxt.st    = CBD_S_PUSH;                  // RULE3
          q_nxt.addr  = q_r.sp;
          q_nxt.rd    = 1'b0;
          q_nxt.wr    = 1'b1;
          q_nxt.wdata = src;
        end
        CBD_C_POP: begin
          q_nxt.sp   = q_r.sp + 16'h0001;            // RULE4
          q_nxt.st   = CBD_S_POP;
          q_nxt.addr = q_r.sp + 16'h0001;
        end
        CBD_C_BRANCH: begin
          if (q_r.opc == `CBD_OP_BRA
              || (q_r.opc != `CBD_OP_BRN && taken_i)) begin
            q_nxt.pc = target;                       // RULE12 RULE13
          end
          q_nxt.st   = CBD_S_FREE;                   // RULE1
          q_nxt.addr = q_r.pc;
        end
        CBD_C_JUMP: begin
          fetch_req = 1'b1;
          fetch_pc  = ea;
        end
        default: begin
          q_nxt.st   = CBD_S_FREE;                   // RULE1
          q_nxt.addr = q_r.pc;
        end
      endcase
    end
    // load a register from a read, pop or immediate
    if (ld_en) begin
      case (rsel)
        CBD_R_ACC: q_nxt.acc       = ld_val;
        CBD_R_X:   q_nxt.hx[7:0]   = ld_val;
        CBD_R_H:   q_nxt.hx[15:8]  = ld_val;
        default:   q_nxt.acc       = q_r.acc;
      endcase
    end
    // next opcode fetch, or a vector at an instruction boundary
    if (fetch_req) begin
      if (vec_req_i && !q_nxt.page2) begin
        q_nxt.st   = CBD_S_VEC_HI;                   // RULE2
        q_nxt.addr = {`CBD_VEC_PAGE, vec_sel_i[7:1], 1'b0};
      end else begin
        q_nxt.st   = CBD_S_FETCH;                    // RULE15
        q_nxt.addr = fetch_pc;
        q_nxt.pc   = fetch_pc + 16'h0001;            // RULE15
      end
    end
  end

  // state register, reset starts with the reset vector
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r       <= '0;
      q_r.st    <= CBD_S_VEC_HI;
      q_r.addr  <= {`CBD_VEC_PAGE, `CBD_RST_VEC_LO};
      q_r.rd    <= 1'b1;
      q_r.sp    <= `CBD_SP_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from the state register
  assign addr_o        = q_r.addr;
  assign rd_o          = q_r.rd;
  assign wr_o          = q_r.wr;
  assign wdata_o       = q_r.wdata;
  assign opcode_o      = q_r.opc;
  assign page2_o       = q_r.page2;
  assign operand_o     = q_r.data;
  assign operand_vld_o = q_r.dvld;
  assign pc_o          = q_r.pc;
  assign sp_o          = q_r.sp;
  assign hx_o          = q_r.hx;
  assign acc_o         = q_r.acc;

  // checks on the bus sequence
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_free_read: assert property ( // RULE1
    q_r.st == CBD_S_FREE |-> rd_o && !wr_o ##1 q_r.st != CBD_S_FREE)
    else $error("free cycle not a single read cycle");

  chk_vec_order: assert property ( // RULE2
    q_r.st == CBD_S_VEC_HI |-> addr_o[15:8] == `CBD_VEC_PAGE
      && !addr_o[0] ##1 q_r.st == CBD_S_VEC_LO
      && addr_o == $past(addr_o) + 16'h0001)
    else $error("vector bytes out of order");

  chk_push_sp: assert property ( // RULE3
    q_r.st == CBD_S_PUSH |-> wr_o && addr_o == q_r.sp
      ##1 q_r.sp == $past(addr_o) - 16'h0001)
    else $error("push not at stack pointer");

  chk_pop_read: assert property ( // RULE4
    q_r.st == CBD_S_POP |-> rd_o && !wr_o && addr_o == q_r.sp)
    else $error("pop not a stack read");

  chk_write_once: assert property ( // RULE5
    q_r.st == CBD_S_WRITE |-> wr_o ##1 q_r.st != CBD_S_WRITE)
    else $error("operand write longer than one cycle");

  chk_opr_count: assert property ( // RULE6
    q_r.st == CBD_S_OPR2 |-> $past(q_r.st) == CBD_S_OPR1)
    else $error("third operand byte fetched");

  chk_post_inc: assert property ( // RULE7
    (q_r.st == CBD_S_READ && mode == CBD_M_IXP) |-> addr_o == q_r.hx
      ##1 q_r.hx == $past(addr_o) + 16'h0001)
    else $error("post increment addressing wrong");

  chk_prebyte: assert property ( // RULE14
    $rose(q_r.page2) |-> $past(q_r.st) == CBD_S_FETCH
      && $past(rdata_i) == `CBD_PREBYTE)
    else $error("page two without prebyte");

  chk_fetch_pc: assert property ( // RULE15
    q_r.st == CBD_S_FETCH |-> rd_o && pc_o == addr_o + 16'h0001)
    else $error("fetch does not advance pc by one");

  cov_vector: cover property (
    q_r.st == CBD_S_VEC_LO ##1 q_r.st == CBD_S_FETCH);
  cov_push_pop: cover property (
    q_r.st == CBD_S_PUSH ##[1:20] q_r.st == CBD_S_POP);
  cov_page2: cover property (
    q_r.page2 && q_r.st == CBD_S_OPR2);
  cov_branch: cover property (
    q_r.st == CBD_S_FREE && $past(q_r.st) == CBD_S_OPR1);

endmodule : cbd_bus_cycle_decoder
`default_nettype wire

// *** cbd_regs.svh ***
`ifndef CBD_REGS_SVH
`define CBD_REGS_SVH

// opcode page select and fixed opcodes
`define CBD_PREBYTE      8'h9E
`define CBD_OP_BRA       8'h20
`define CBD_OP_BRN       8'h21
`define CBD_OP_POP_ACC   8'h86
`define CBD_OP_PUSH_ACC  8'h87
`define CBD_OP_POP_X     8'h88
`define CBD_OP_PUSH_X    8'h89
`define CBD_OP_POP_H     8'h8A
`define CBD_OP_PUSH_H    8'h8B

// vector page, direct page and reset values
`define CBD_VEC_PAGE     8'hFF
`define CBD_RST_VEC_LO   8'hFE
`define CBD_SP_RESET     16'h00FF
`define CBD_DIR_PAGE     8'h00

`endif

// *** cbd_pkg.sv ***
package cbd_pkg;

  // bus cycle sequencer states
  typedef enum logic [3:0] {
    CBD_S_VEC_HI,
    CBD_S_VEC_LO,
    CBD_S_FETCH,
    CBD_S_OPR1,
    CBD_S_OPR2,
    CBD_S_FREE,
    CBD_S_READ,
    CBD_S_WRITE,
    CBD_S_PUSH,
    CBD_S_POP
  } cbd_state_t;

  // addressing modes
  typedef enum logic [3:0] {
    CBD_M_INH,
    CBD_M_IMM,
    CBD_M_DIR,
    CBD_M_EXT,
    CBD_M_IX,
    CBD_M_IX1,
    CBD_M_IX2,
    CBD_M_IXP,
    CBD_M_IX1P,
    CBD_M_SP1,
    CBD_M_SP2,
    CBD_M_REL
  } cbd_mode_t;

  // instruction cycle classes
  typedef enum logic [2:0] {
    CBD_C_FREE,
    CBD_C_READ,
    CBD_C_WRITE,
    CBD_C_PUSH,
    CBD_C_POP,
    CBD_C_BRANCH,
    CBD_C_JUMP
  } cbd_cls_t;

  // register source or target
  typedef enum logic [1:0] {
    CBD_R_ACC,
    CBD_R_X,
    CBD_R_H,
    CBD_R_NONE
  } cbd_reg_t;

  // all sequencer state
  typedef struct packed {
    cbd_state_t  st;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] hx;
    logic [7:0]  acc;
    logic [7:0]  opc;
    logic        page2;
    logic [15:0] opr;
    logic [1:0]  nleft;
    logic [7:0]  data;
    logic        dvld;
  } cbd_seq_t;

endpackage : cbd_pkg

// *** cbd_mode_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module cbd_mode_decode import cbd_pkg::*; (
  // opcode in
  input  wire logic [7:0] opc_i,
  input  wire logic       page2_i,
  // decoded fields
  output cbd_mode_t       mode_o,
  output cbd_cls_t        cls_o,
  output logic [1:0]      nbytes_o,
  output cbd_reg_t        rsel_o
);
`include "cbd_regs.svh"

  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = opc_i[7:4];
  assign lo = opc_i[3:0];

  // mode, operand length and cycle class per opcode
  always_comb begin
    mode_o   = CBD_M_INH;
    cls_o    = CBD_C_FREE;
    nbytes_o = 2'h0;
    rsel_o   = CBD_R_NONE;
    if (page2_i) begin
      if (hi == 4'h6 || hi == 4'hE) begin
        mode_o   = CBD_M_SP1;                       // RULE10
        nbytes_o = 2'h1;
      end else if (hi == 4'hD) begin
        mode_o   = CBD_M_SP2;                       // RULE11
        nbytes_o = 2'h2;
      end
      if (mode_o != CBD_M_INH) begin
        cls_o = CBD_C_READ;
        if (hi != 4'h6 && (lo == 4'h7 || lo == 4'hF)) begin
          cls_o = CBD_C_WRITE;
        end
      end
    end else if (hi == 4'h2) begin
      mode_o   = CBD_M_REL;                         // RULE12
      cls_o    = CBD_C_BRANCH;
      nbytes_o = 2'h1;
    end else if (opc_i == 8'h71) begin
      mode_o   = CBD_M_IXP;                         // RULE7
      cls_o    = CBD_C_READ;
      nbytes_o = 2'h1;
    end else if (opc_i == 8'h61) begin
      mode_o   = CBD_M_IX1P;                        // RULE8
      cls_o    = CBD_C_READ;
      nbytes_o = 2'h2;
    end else if (hi == 4'h3 || hi == 4'h6 || hi == 4'h7) begin
      cls_o = CBD_C_READ;
      case (hi)
        4'h3: begin
          mode_o   = CBD_M_DIR;
          nbytes_o = 2'h1;
        end
        4'h6: begin
          mode_o   = CBD_M_IX1;
          nbytes_o = 2'h1;
        end
        default: mode_o = CBD_M_IX;
      endcase
    end else if (hi >= 4'hA) begin
      cls_o = CBD_C_READ;
      case (hi)
        4'hA: begin
          mode_o   = CBD_M_IMM;
          nbytes_o = 2'h1;
        end
        4'hB: begin
          mode_o   = CBD_M_DIR;
          nbytes_o = 2'h1;
        end
        4'hC: begin
          mode_o   = CBD_M_EXT;
          nbytes_o = 2'h2;
        end
        4'hD: begin
          mode_o   = CBD_M_IX2;                     // RULE9
          nbytes_o = 2'h2;
        end
        4'hE: begin
          mode_o   = CBD_M_IX1;                     // RULE9
          nbytes_o = 2'h1;
        end
        default: mode_o = CBD_M_IX;
      endcase
      if (hi != 4'hA && (lo == 4'h7 || lo == 4'hF)) begin
        cls_o = CBD_C_WRITE;
      end else if (hi != 4'hA && lo == 4'hC) begin
        cls_o = CBD_C_JUMP;
      end
    end else begin
      case (opc_i)
        `CBD_OP_PUSH_ACC, `CBD_OP_PUSH_X, `CBD_OP_PUSH_H: cls_o = CBD_C_PUSH;
        `CBD_OP_POP_ACC, `CBD_OP_POP_X, `CBD_OP_POP_H:    cls_o = CBD_C_POP;
        default: cls_o = CBD_C_FREE;
      endcase
    end
    // register moved by loads, stores, pushes and pops
    case (opc_i)
      `CBD_OP_PUSH_ACC, `CBD_OP_POP_ACC: rsel_o = CBD_R_ACC;
      `CBD_OP_PUSH_X, `CBD_OP_POP_X:     rsel_o = CBD_R_X;
      `CBD_OP_PUSH_H, `CBD_OP_POP_H:     rsel_o = CBD_R_H;
      default: begin
        if (hi >= 4'hA && (lo == 4'h6 || lo == 4'h7)) begin
          rsel_o = CBD_R_ACC;
        end else if (hi >= 4'hA && (lo == 4'hE || lo == 4'hF)) begin
          rsel_o = CBD_R_X;
        end
      end
    endcase
  end

endmodule : cbd_mode_decode
`default_nettype wire

// *** cbd_addr_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
module cbd_addr_gen import cbd_pkg::*; (
  // mode and base registers
  input  wire cbd_mode_t   mode_i,
  input  wire logic [15:0] hx_i,
  input  wire logic [15:0] sp_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [15:0] opr_i,
  // addresses
  output logic [15:0]      ea_o,
  output logic [15:0]      target_o
);
`include "cbd_regs.svh"

  // effective address per mode
  always_comb begin
    case (mode_i)
      CBD_M_DIR:  ea_o = {`CBD_DIR_PAGE, opr_i[7:0]};
      CBD_M_EXT:  ea_o = opr_i;
      CBD_M_IX:   ea_o = hx_i;
      CBD_M_IXP:  ea_o = hx_i;                           // RULE7
      CBD_M_IX1:  ea_o = hx_i + {8'h00, opr_i[7:0]};     // RULE9
      CBD_M_IX1P: ea_o = hx_i + {8'h00, opr_i[15:8]};    // RULE8
      CBD_M_IX2:  ea_o = hx_i + opr_i;                   // RULE9
      CBD_M_SP1:  ea_o = sp_i + {8'h00, opr_i[7:0]};     // RULE10
      CBD_M_SP2:  ea_o = sp_i + opr_i;                   // RULE11
      default:    ea_o = opr_i;
    endcase
  end

  // signed displacement from the following instruction
  assign target_o = pc_i + {{8{opr_i[7]}}, opr_i[7:0]}; // RULE12 RULE13

endmodule : cbd_addr_gen
`default_nettype wire

// *** cbd_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cbd_mem_model (
  // clock
  input  wire logic        clk_i,
  // bus from the core
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i,
  // read data back to the core
  output logic [7:0]       rdata_o
);
  // byte array and the last byte that was driven
  logic [7:0] mem_r [0:65535];
  logic [7:0] last_r;

  // cleared at start so that no place reads as unknown
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_r[i] = 8'h00;
    end
    last_r = 8'h00;
  end

  // zero-wait read; outside reads the lines show a changed value, not a hold
  assign rdata_o = rd_i ? mem_r[addr_i] : ~last_r;

  // a write lands at the edge that ends the write cycle
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    if (rd_i) begin
      last_r <= mem_r[addr_i];
    end
  end
endmodule : cbd_mem_model
`default_nettype wire

// *** tb_cbd_bus_cycle_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_cbd_bus_cycle_decoder;
  // clock, reset and execution side inputs
  logic        clk_i;
  logic        rst_i;
  logic        taken_i;
  logic        vec_req_i;
  logic [7:0]  vec_sel_i;
  logic [7:0]  rdata_i;
  // design outputs
  logic [15:0] addr_o;
  logic        rd_o;
  logic        wr_o;
  logic [7:0]  wdata_o;
  logic [7:0]  opcode_o;
  logic        page2_o;
  logic [7:0]  operand_o;
  logic        operand_vld_o;
  logic [15:0] pc_o;
  logic [15:0] sp_o;
  logic [15:0] hx_o;
  logic [7:0]  acc_o;
  // bookkeeping
  int          error_cnt;
  int          comparisons;
  logic [7:0]  prog [0:24];

  cbd_bus_cycle_decoder dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_o(addr_o), .rd_o(rd_o),
    .wr_o(wr_o), .wdata_o(wdata_o), .rdata_i(rdata_i),
    .taken_i(taken_i), .vec_req_i(vec_req_i), .vec_sel_i(vec_sel_i),
    .opcode_o(opcode_o), .page2_o(page2_o), .operand_o(operand_o),
    .operand_vld_o(operand_vld_o), .pc_o(pc_o), .sp_o(sp_o),
    .hx_o(hx_o), .acc_o(acc_o)
  );

  cbd_mem_model mem_model (
    .clk_i(clk_i), .addr_i(addr_o), .rd_i(rd_o), .wr_i(wr_o),
    .wdata_i(wdata_o), .rdata_o(rdata_i)
  );

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // checks one bus cycle at its falling edge, then moves to the next one
  task automatic cyc(input logic [15:0] a, input logic r, input logic w,
                     input logic [7:0] d);
    comparisons++;
    if ({addr_o, rd_o, wr_o} !== {a, r, w} || (w && wdata_o !== d)) begin
      error_cnt++;
      $display("wrong value at %0t: bus %h %b%b %h, expected %h %b%b %h",
               $time, addr_o, rd_o, wr_o, wdata_o, a, r, w, d);
    end
    @(negedge clk_i);
  endtask : cyc

  task automatic rdc(input logic [15:0] a);
    cyc(a, 1'b1, 1'b0, 8'h00);
  endtask : rdc

  // compares a register or flag value
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: register %h, expected %h",
               $time, got, exp);
    end
  endtask : chk_reg

  // program and data image
  task automatic load_prog;
    prog = '{8'hC6, 8'h34, 8'h56, 8'h87, 8'h86, 8'h71, 8'h00, 8'h61,
             8'h10, 8'h00, 8'hE6, 8'h20, 8'hD6, 8'h01, 8'h00, 8'h9E,
             8'hE6, 8'h05, 8'h9E, 8'hD6, 8'h02, 8'h00, 8'h9D, 8'h20,
             8'h80};
    for (int i = 0; i < 25; i++) begin
      mem_model.mem_r[16'h1200 + i] = prog[i];
    end
    mem_model.mem_r[16'h1199] = 8'h20;
    mem_model.mem_r[16'h119A] = 8'h7F;
    mem_model.mem_r[16'h121A] = 8'h26;
    mem_model.mem_r[16'h121B] = 8'h40;
    mem_model.mem_r[16'h121C] = 8'h27;
    mem_model.mem_r[16'h121D] = 8'h05;
    mem_model.mem_r[16'h1223] = 8'hF7;
    mem_model.mem_r[16'h1300] = 8'hA6;
    mem_model.mem_r[16'h1301] = 8'h5C;
    mem_model.mem_r[16'h1302] = 8'h21;
    mem_model.mem_r[16'h1303] = 8'h10;
    mem_model.mem_r[16'h1304] = 8'hCC;
    mem_model.mem_r[16'h1305] = 8'h12;
    mem_model.mem_r[16'h1306] = 8'h00;
    mem_model.mem_r[16'h3456] = 8'hA5;
    mem_model.mem_r[16'h0022] = 8'h5A;
    mem_model.mem_r[16'h0102] = 8'h3C;
    mem_model.mem_r[16'h0104] = 8'h11;
    mem_model.mem_r[16'h02FF] = 8'h77;
    mem_model.mem_r[16'hFFFE] = 8'h12;
    mem_model.mem_r[16'hFFFF] = 8'h00;
    mem_model.mem_r[16'hFFF8] = 8'h13;
    mem_model.mem_r[16'hFFF9] = 8'h00;
  endtask : load_prog

  // extended load: two operand bytes, one data read, then next fetch
  task automatic t_ext_read;
    rdc(16'h1200);
    rdc(16'h1201);
    rdc(16'h1202);
    rdc(16'h3456);
    chk_reg({15'h0000, operand_vld_o}, 16'h0001);
    chk_reg({8'h00, acc_o}, 16'h00A5);
    chk_reg({8'h00, operand_o}, 16'h00A5);
    chk_reg({8'h00, opcode_o}, 16'h00C6);
    chk_reg(pc_o, 16'h1204);
  endtask : t_ext_read

  // push then pop of the accumulator
  task automatic t_stack;
    rdc(16'h1203);
    cyc(16'h00FF, 1'b0, 1'b1, 8'hA5);
    chk_reg(sp_o, 16'h00FE);
    rdc(16'h1204);
    rdc(16'h00FF);
    chk_reg(sp_o, 16'h00FF);
  endtask : t_stack

  // both post-increment forms, back to back
  task automatic t_post_inc;
    rdc(16'h1205);
    rdc(16'h1206);
    rdc(16'h0000);
    rdc(16'h1207);
    rdc(16'h1208);
    rdc(16'h1209);
    rdc(16'h0011);
  endtask : t_post_inc

  // short and long index offsets
  task automatic t_index_offsets;
    rdc(16'h120A);
    rdc(16'h120B);
    rdc(16'h0022);
    chk_reg({8'h00, acc_o}, 16'h005A);
    rdc(16'h120C);
    rdc(16'h120D);
    rdc(16'h120E);
    rdc(16'h0102);
    chk_reg(hx_o, 16'h0002);
  endtask : t_index_offsets

  // second page opcodes with stack-relative addresses
  task automatic t_stack_rel;
    rdc(16'h120F);
    chk_reg({15'h0000, page2_o}, 16'h0001);
    rdc(16'h1210);
    rdc(16'h1211);
    rdc(16'h0104);
    chk_reg({8'h00, acc_o}, 16'h0011);
    rdc(16'h1212);
    rdc(16'h1213);
    rdc(16'h1214);
    rdc(16'h1215);
    rdc(16'h02FF);
    chk_reg({8'h00, acc_o}, 16'h0077);
  endtask : t_stack_rel

  // inherent opcode spends a single free read cycle
  task automatic t_free;
    rdc(16'h1216);
    rdc(16'h1217);
  endtask : t_free

  // extreme displacements, then not-taken and taken conditionals
  task automatic t_branch;
    taken_i = 1'b0;
    rdc(16'h1217);
    rdc(16'h1218);
    rdc(16'h1219);
    rdc(16'h1199);
    rdc(16'h119A);
    rdc(16'h119B);
    rdc(16'h121A);
    rdc(16'h121B);
    rdc(16'h121C);
    taken_i = 1'b1;
    rdc(16'h121C);
    rdc(16'h121D);
    rdc(16'h121E);
  endtask : t_branch

  // indexed store, then a vector request at the next boundary
  task automatic t_write_vector;
    rdc(16'h1223);
    vec_req_i = 1'b1;
    vec_sel_i = 8'hF8;
    cyc(16'h0002, 1'b0, 1'b1, 8'h77);
    vec_req_i = 1'b0;
    rdc(16'hFFF8);
    rdc(16'hFFF9);
    rdc(16'h1300);
  endtask : t_write_vector

  // immediate load, never-taken branch and extended jump
  task automatic t_imm_jump;
    rdc(16'h1301);
    chk_reg({8'h00, acc_o}, 16'h005C);
    rdc(16'h1302);
    rdc(16'h1303);
    rdc(16'h1304);
    rdc(16'h1304);
    rdc(16'h1305);
    rdc(16'h1306);
    rdc(16'h1200);
  endtask : t_imm_jump

  // reset in mid-run restarts from the reset vector
  task automatic t_mid_reset;
    rst_i = 1'b1;
    #1;
    chk_reg(sp_o, 16'h00FF);
    chk_reg(pc_o, 16'h0000);
    chk_reg(hx_o, 16'h0000);
    chk_reg({15'h0000, operand_vld_o}, 16'h0000);
    cyc(16'hFFFE, 1'b1, 1'b0, 8'h00);
    rst_i = 1'b0;
    rdc(16'hFFFE);
    rdc(16'hFFFF);
    rdc(16'h1200);
  endtask : t_mid_reset

  // hang guard
  initial begin
    repeat (2000) @(posedge clk_i);
    error_cnt++;
    $display("wrong value at %0t: run did not finish", $time);
    stop_test();
  end

  // main sequence
  initial begin
    error_cnt = 0;
    comparisons = 0;
    rst_i = 1'b1;
    taken_i = 1'b0;
    vec_req_i = 1'b0;
    vec_sel_i = 8'h00;
    @(negedge clk_i);
    load_prog();
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    rdc(16'hFFFE);
    rdc(16'hFFFF);
    t_ext_read();
    t_stack();
    t_post_inc();
    t_index_offsets();
    t_stack_rel();
    t_free();
    t_branch();
    t_write_vector();
    t_imm_jump();
    t_mid_reset();
    stop_test();
  end
endmodule : tb_cbd_bus_cycle_decoder
`default_nettype wire
